// *** rtl/cxp_params.svh ***
// constants of the crosspoint serial configuration port
`ifndef CXP_PARAMS_SVH
`define CXP_PARAMS_SVH

`define CXP_OUTPUTS      8
`define CXP_ENTRY_BITS   5
`define CXP_FRAME_BITS   40
`define CXP_WORD_BITS    8
`define CXP_CNT_BITS     6
`define CXP_CNT_MAX      6'h3f
`define CXP_FULL_COUNT   6'h28
`define CXP_ADDR_COUNT   6'h08

// entry layout: select bits 3:0 lsb first, bit 4 high means output off
`define CXP_ENTRY_SEL_LSB 0
`define CXP_ENTRY_SEL_MSB 3
`define CXP_ENTRY_OFF_BIT 4
`define CXP_ENTRY_RST     5'h10

// addressed word, as it sits in the top byte of the shift register
`define CXP_WORD_BASE     32
`define CXP_WORD_IDX_LSB  0
`define CXP_WORD_IDX_MSB  2
`define CXP_WORD_SEL_LSB  3
`define CXP_WORD_SEL_MSB  6
`define CXP_WORD_OFF_BIT  7

`endif

// *** rtl/cxp_pkg.sv ***
// types of the crosspoint serial configuration port
package cxp_pkg;

  typedef enum logic
  {
    CXP_FMT_FULL = 1'b0,
    CXP_FMT_ADDR = 1'b1
  } cxp_fmt_e;

  typedef enum logic [1:0]
  {
    CXP_LS_IDLE  = 2'b00,
    CXP_LS_ARMED = 2'b01
  } cxp_link_e;

  typedef logic [4:0] cxp_entry_t;

endpackage

// *** rtl/cxp_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
module cxp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("cxp_sync: WIDTH must be at least 1");
  end

  // first stage is read by the second stage only
  always_comb
  begin
    next_stage1 = async_in;
    next_sync   = stage1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= next_stage1;
      sync_out <= next_sync;
    end
  end

endmodule

// *** rtl/cxp_stage_bank.sv ***
// staging bank: one routing entry per output, written from the link side
`timescale 1ns/1ps
`include "cxp_params.svh"
module cxp_stage_bank #(
  parameter int OUTPUTS    = `CXP_OUTPUTS,
  parameter int ENTRY_BITS = `CXP_ENTRY_BITS
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          load_all_in,
  input  wire logic                          load_one_in,
  input  wire logic [$clog2(OUTPUTS)-1:0]    index_in,
  input  wire logic [ENTRY_BITS-1:0]         entry_in,
  input  wire logic [OUTPUTS*ENTRY_BITS-1:0] frame_in,
  output logic      [OUTPUTS*ENTRY_BITS-1:0] bank_out
);

  localparam int IDXW = $clog2(OUTPUTS);

  if (OUTPUTS < 2 || ENTRY_BITS != `CXP_ENTRY_BITS)
  begin : g_bad_shape
    $error("cxp_stage_bank: unsupported shape");
  end

  for (genvar i = 0; i < OUTPUTS; i++)
  begin : g_entry
    logic [ENTRY_BITS-1:0] next_entry;

    always_comb
    begin
      next_entry = bank_out[i*ENTRY_BITS +: ENTRY_BITS];
      if (load_all_in)
        next_entry = frame_in[i*ENTRY_BITS +: ENTRY_BITS];
      else if (load_one_in && index_in == IDXW'(i))
        next_entry = entry_in;
    end

    // read data leaves straight from the entry flops
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
        bank_out[i*ENTRY_BITS +: ENTRY_BITS] <= `CXP_ENTRY_RST;
      else
        bank_out[i*ENTRY_BITS +: ENTRY_BITS] <= next_entry;
    end
  end

endmodule

// *** rtl/cxp_config_port.sv ***
// serial configuration port of a 16x8 crosspoint: shift, stage, apply
//
// Contract
// - active routing registers plus separate staging bank
// - select_n high makes clock and data ignored; the first rising edge after select_n rises still stages the frame
// - first rising edge arms, falling edge captures
// - serial data sampled only on falling edges
// - staged data reaches matrix only on apply
// - apply acts whatever level select_n has
// - apply without new data changes nothing
// - three-wire use with apply tied to select_n
// - format_select high addressed, low full frame
// - format_select and apply independent of select_n
// - full frame is 40 bits for 8 outputs
// - frame bit0 first; five bits per output
// - load register shifts on, old bits out
// - addressed word updates one staging entry only
// - word: index bits0-2, select 3-6, off 7
`timescale 1ns/1ps
`include "cxp_params.svh"
module cxp_config_port #(
  parameter int OUTPUTS    = `CXP_OUTPUTS,
  parameter int ENTRY_BITS = `CXP_ENTRY_BITS
) (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        shift_clock_in,
  input  wire logic                        select_n_in,
  input  wire logic                        serial_data_in,
  input  wire logic                        apply_in,
  input  wire logic                        format_select_in,
  output logic                             serial_data_out,
  output logic      [OUTPUTS*4-1:0]        route_sel_out,
  output logic      [OUTPUTS-1:0]          route_off_out,
  output logic                             staged_pending_out
);

  localparam int FRAME = OUTPUTS * ENTRY_BITS;
  localparam int IDXW  = $clog2(OUTPUTS);

  if (OUTPUTS != `CXP_OUTPUTS || FRAME != `CXP_FRAME_BITS)
  begin : g_bad_shape
    $error("cxp_config_port: only the 8 x 5 bit layout is supported");
  end

  // ---------------- link domain, clocked by shift_clock_in
  cxp_pkg::cxp_link_e           link_state;
  cxp_pkg::cxp_link_e           next_link_state;
  cxp_pkg::cxp_fmt_e            link_fmt;
  logic [FRAME-1:0]             shift_reg;
  logic [FRAME-1:0]             next_shift_reg;
  logic [`CXP_CNT_BITS-1:0]     bit_count;
  logic [`CXP_CNT_BITS-1:0]     next_bit_count;
  logic [`CXP_CNT_BITS-1:0]     needed_count;
  logic                         commit;
  logic                         load_all;
  logic                         load_one;
  logic                         stage_toggle;
  logic                         next_stage_toggle;
  logic [FRAME-1:0]             stage_bank;
  logic [`CXP_WORD_BITS-1:0]    addr_word;
  logic [IDXW-1:0]              addr_index;
  logic [ENTRY_BITS-1:0]        addr_entry;

  // format pin is held steady by the host across a frame
  assign link_fmt = cxp_pkg::cxp_fmt_e'(format_select_in);

  // rising edges only arm or close a frame, never take data
  always_comb
  begin
    if (select_n_in)
      next_link_state = cxp_pkg::CXP_LS_IDLE;
    else
      next_link_state = cxp_pkg::CXP_LS_ARMED;
  end

  always_ff @(posedge shift_clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      link_state <= cxp_pkg::CXP_LS_IDLE;
    else
      link_state <= next_link_state;
  end

  // data is taken on falling edges while armed and selected
  always_comb
  begin
    next_shift_reg = shift_reg;
    next_bit_count = bit_count;
    if (link_state == cxp_pkg::CXP_LS_ARMED && !select_n_in)
    begin
      // newest bit enters at the top, oldest leaves at bit 0
      next_shift_reg = {serial_data_in, shift_reg[FRAME-1:1]};
      if (bit_count != `CXP_CNT_MAX)
        next_bit_count = bit_count + `CXP_CNT_BITS'(1);
    end
    else if (link_state == cxp_pkg::CXP_LS_IDLE)
      next_bit_count = '0;
  end

  always_ff @(negedge shift_clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      shift_reg <= '0;
      bit_count <= '0;
    end
    else
    begin
      shift_reg <= next_shift_reg;
      bit_count <= next_bit_count;
    end
  end

  assign serial_data_out = shift_reg[0];

  // a frame is staged at the first rising edge after select_n rises;
  // short frames are dropped rather than staging partial data
  assign needed_count = (link_fmt == cxp_pkg::CXP_FMT_ADDR) ?
                        `CXP_ADDR_COUNT : `CXP_FULL_COUNT;
  assign commit = (link_state == cxp_pkg::CXP_LS_ARMED) && select_n_in &&
                  (bit_count >= needed_count);
  assign load_all = commit && (link_fmt == cxp_pkg::CXP_FMT_FULL);
  assign load_one = commit && (link_fmt == cxp_pkg::CXP_FMT_ADDR);

  // the last eight bits shifted in sit at the top of the register
  assign addr_word  = shift_reg[`CXP_WORD_BASE +: `CXP_WORD_BITS];
  assign addr_index = addr_word[`CXP_WORD_IDX_MSB:`CXP_WORD_IDX_LSB];
  assign addr_entry = {addr_word[`CXP_WORD_OFF_BIT],
                       addr_word[`CXP_WORD_SEL_MSB:`CXP_WORD_SEL_LSB]};

  cxp_stage_bank #(
    .OUTPUTS    (OUTPUTS),
    .ENTRY_BITS (ENTRY_BITS)
  ) u_stage_bank (
    .clk_in      (shift_clock_in),
    .rst_n_in    (rst_n_in),
    .load_all_in (load_all),
    .load_one_in (load_one),
    .index_in    (addr_index),
    .entry_in    (addr_entry),
    .frame_in    (shift_reg),
    .bank_out    (stage_bank)
  );

  // event toward the system clock; the bank stays still for many
  // clk_in cycles after it, as frames are at least eight bits long
  always_comb
  begin
    next_stage_toggle = stage_toggle ^ commit;
  end

  always_ff @(posedge shift_clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      stage_toggle <= 1'b0;
    else
      stage_toggle <= next_stage_toggle;
  end

  // ---------------- system domain, clocked by clk_in
  logic [1:0]       sync_bits;
  logic             toggle_sync;
  logic             apply_sync;
  logic             toggle_seen;
  logic             next_toggle_seen;
  logic             new_stage;
  logic             pending;
  logic             next_pending;
  logic [FRAME-1:0] shadow;
  logic [FRAME-1:0] next_shadow;
  logic [FRAME-1:0] active;
  logic [FRAME-1:0] next_active;

  cxp_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({apply_in, stage_toggle}),
    .sync_out (sync_bits)
  );

  assign toggle_sync = sync_bits[0];
  assign apply_sync  = sync_bits[1];
  assign new_stage   = toggle_sync != toggle_seen;

  // apply is level-sensitive so that a strobe tied to select_n,
  // which rises before the frame is staged, still lands it
  always_comb
  begin
    next_toggle_seen = toggle_sync;
    next_shadow      = shadow;
    next_pending     = pending;
    next_active      = active;
    if (apply_sync && pending)
    begin
      next_active  = shadow;
      next_pending = 1'b0;
    end
    if (new_stage)
    begin
      // a fresh frame beats a clear in the same cycle
      next_shadow  = stage_bank;
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      toggle_seen <= 1'b0;
      pending     <= 1'b0;
      shadow      <= {OUTPUTS{`CXP_ENTRY_RST}};
      active      <= {OUTPUTS{`CXP_ENTRY_RST}};
    end
    else
    begin
      toggle_seen <= next_toggle_seen;
      pending     <= next_pending;
      shadow      <= next_shadow;
      active      <= next_active;
    end
  end

  assign staged_pending_out = pending;

  // active entries drive the matrix and are not readable over the port
  for (genvar i = 0; i < OUTPUTS; i++)
  begin : g_route
    assign route_sel_out[i*4 +: 4] =
      active[i*ENTRY_BITS + `CXP_ENTRY_SEL_LSB +: 4];
    assign route_off_out[i] =
      active[i*ENTRY_BITS + `CXP_ENTRY_OFF_BIT];
  end

endmodule

// *** bench/cxp_config_port_props.sv ***
// assertions on the ports of the crosspoint serial configuration port
`timescale 1ns/1ps
module cxp_config_port_props #(
  parameter int OUTPUTS    = 8,
  parameter int ENTRY_BITS = 5
) (
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  input wire logic                 select_n_in,
  input wire logic                 apply_in,
  input wire logic                 serial_data_out,
  input wire logic [OUTPUTS*4-1:0] route_sel_out,
  input wire logic [OUTPUTS-1:0]   route_off_out,
  input wire logic                 staged_pending_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // apply reaches the matrix through three flops (two sync, then active), so look two to four back
  reset_values_a: assert property ($rose(rst_n_in) |-> route_sel_out == '0 && route_off_out == '1 && !staged_pending_out) else $error("bad reset value");
  sel_needs_apply_a: assert property ($changed(route_sel_out) |-> $past(apply_in, 2) || $past(apply_in, 3) || $past(apply_in, 4)) else $error("select moved without apply");
  off_needs_pend_a: assert property ($changed(route_off_out) |-> $past(staged_pending_out)) else $error("off moved without staged data");
  sel_needs_pend_a: assert property ($changed(route_sel_out) |-> $past(staged_pending_out)) else $error("select moved without staged data");
  pend_clear_a: assert property ($fell(staged_pending_out) |-> $past(apply_in, 2) || $past(apply_in, 3) || $past(apply_in, 4)) else $error("pending cleared without apply");
  apply_takes_a: assert property ((staged_pending_out && apply_in) [*3] |-> ##[1:3] !staged_pending_out) else $error("apply not taken");
  stage_holds_a: assert property ($rose(staged_pending_out) |-> $stable(route_sel_out) && $stable(route_off_out)) else $error("staging hit the matrix");
  idle_out_a: assert property (select_n_in && $past(select_n_in) |-> $stable(serial_data_out)) else $error("serial out moved while idle");
  cover_stage_c: cover property ($rose(staged_pending_out));
  cover_apply_c: cover property ($fell(staged_pending_out));
  cover_route_c: cover property ($changed(route_off_out));
endmodule

// *** bench/cxp_host_model.sv ***
// host model driving the serial configuration pins
`timescale 1ns/1ps
module cxp_host_model (
  output logic sck_out,
  output logic csn_out,
  output logic sdo_out,
  output logic fmt_out
);
  initial
  begin
    sck_out = 1'b0;
    csn_out = 1'b1;
    sdo_out = 1'b0;
    fmt_out = 1'b0;
  end

  // bit 0 first; clock rests low between frames
  task automatic send(input logic fmt, input int n,
                      input logic [47:0] bits, input logic csn);
    fmt_out = fmt;
    csn_out = csn;
    #32 sck_out = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      #16 sdo_out = bits[i];
      #16 sck_out = 1'b0;
      if (i < n - 1)
        #32 sck_out = 1'b1;
    end
    #16 csn_out = 1'b1;
    sdo_out = ~sdo_out;
    #16 sck_out = 1'b1;
    #32 sck_out = 1'b0;
  endtask
endmodule

// *** bench/cxp_config_port_tb.sv ***
// self-checking bench of the crosspoint serial configuration port
`timescale 1ns/1ps
module cxp_config_port_tb;
  logic        clk_in;
  logic        rst_n_in;
  logic        apply_in;
  wire logic   sck;
  wire logic   csn;
  wire logic   sdi;
  wire logic   fmt;
  logic        serial_data_out;
  logic [31:0] route_sel_out;
  logic [7:0]  route_off_out;
  logic        staged_pending_out;
  logic [31:0] exp_sel;
  logic [7:0]  exp_off;
  logic [47:0] frame;
  int          fails;
  int          cmp_count;

  cxp_host_model host (.sck_out(sck), .csn_out(csn), .sdo_out(sdi),
                       .fmt_out(fmt));
  cxp_config_port uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .shift_clock_in(sck), .select_n_in(csn), .serial_data_in(sdi),
    .apply_in(apply_in), .format_select_in(fmt),
    .serial_data_out(serial_data_out), .route_sel_out(route_sel_out),
    .route_off_out(route_off_out),
    .staged_pending_out(staged_pending_out));

  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;

  task automatic chk(input string what, input logic [39:0] exp,
                     input logic [39:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_pend(input logic v);
    int k;
    k = 0;
    while (staged_pending_out !== v && k < 200)
    begin
      @(negedge clk_in);
      k++;
    end
    if (k == 200)
    begin
      fails++;
      close_out();
    end
  endtask

  // held four cycles so the two-flop sync surely sees it
  task automatic apply_pulse;
    @(negedge clk_in);
    apply_in = 1'b1;
    repeat (4) @(negedge clk_in);
    apply_in = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask

  task automatic chk_route;
    chk("route_sel", {8'h00, exp_sel}, {8'h00, route_sel_out});
    chk("route_off", {32'h0, exp_off}, {32'h0, route_off_out});
  endtask

  task automatic chk_pend(input logic v);
    chk("pending", {39'h0, v}, {39'h0, staged_pending_out});
  endtask

  initial
  begin
    fails = 0;
    cmp_count = 0;
    rst_n_in = 1'b0;
    apply_in = 1'b0;
    exp_sel = '0;
    exp_off = 8'hff;
    frame = '0;
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    chk_route();
    chk_pend(1'b0);
    for (int n = 0; n < 8; n++)
      frame[5*n +: 5] = {n[0], 4'(15 - n)};
    host.send(1'b0, 40, frame, 1'b1);
    repeat (10) @(negedge clk_in);
    chk_pend(1'b0);
    host.send(1'b0, 40, frame, 1'b0);
    wait_pend(1'b1);
    chk_route();
    for (int n = 0; n < 8; n++)
    begin
      exp_sel[4*n +: 4] = 4'(15 - n);
      exp_off[n] = n[0];
    end
    apply_pulse();
    chk_route();
    chk_pend(1'b0);
    apply_pulse();
    chk_route();
    frame = {40'h0, 8'h4d};
    host.send(1'b1, 8, frame, 1'b0);
    wait_pend(1'b1);
    apply_pulse();
    exp_sel[23:20] = 4'h9;
    exp_off[5] = 1'b0;
    chk_route();
    frame[7:0] = 8'ha5;
    for (int n = 0; n < 8; n++)
      frame[8 + 5*n +: 5] = {1'b0, 4'(n + 1)};
    host.send(1'b0, 48, frame, 1'b0);
    chk("serial_out", {39'h0, frame[8]}, {39'h0, serial_data_out});
    wait_pend(1'b1);
    apply_pulse();
    for (int n = 0; n < 8; n++)
      exp_sel[4*n +: 4] = 4'(n + 1);
    exp_off = 8'h00;
    chk_route();
    close_out();
  end
endmodule

bind cxp_config_port cxp_config_port_props #(
  .OUTPUTS(OUTPUTS), .ENTRY_BITS(ENTRY_BITS)) props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .select_n_in(select_n_in),
  .apply_in(apply_in), .serial_data_out(serial_data_out),
  .route_sel_out(route_sel_out), .route_off_out(route_off_out),
  .staged_pending_out(staged_pending_out));
